// ==== common/scs_pkg.sv ====
// Constants and carrier types for the system configuration register block.
// Assumes a simple word-wide register port with secure/privilege attributes.
package scs_pkg;

   // ------------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_EXT_SEL_2   = 8'h10;
   localparam logic [7:0] OFS_EXT_SEL_3   = 8'h14;
   localparam logic [7:0] OFS_COMP_CTRL   = 8'h20;
   localparam logic [7:0] OFS_SEC_ATTR    = 8'h40;
   localparam logic [7:0] OFS_FLOAT_IRQ   = 8'h48;
   localparam logic [7:0] OFS_NS_LOCK     = 8'h4c;
   localparam logic [7:0] OFS_S_LOCK      = 8'h50;
   localparam logic [7:0] OFS_SAFETY_CFG  = 8'h54;

   // ------------------------------------------------------------------
   // Field layout and reset values
   // ------------------------------------------------------------------
   localparam int SEL_W           = 4;
   localparam int NUM_LINES       = 8;
   localparam int SEL_REG_W       = 16;
   localparam int COMP_ON_BIT     = 0;
   localparam int COMP_RDY_BIT    = 8;
   localparam int SEC_ATTR_W      = 4;
   localparam int FLOAT_W         = 6;
   localparam int NS_LOCK_W       = 2;
   localparam int S_LOCK_W        = 3;
   localparam int SAFE_HANG_BIT   = 0;
   localparam int SAFE_LOWV_BIT   = 2;
   localparam int ATTR_CLK_BIT    = 0;
   localparam int ATTR_SAFE_BIT   = 1;
   localparam int ATTR_RAM_BIT    = 2;
   localparam int ATTR_FLOAT_BIT  = 3;

   localparam logic [FLOAT_W-1:0] FLOAT_RESET = 6'h1f;

   // Port codes of a line selector
   localparam logic [SEL_W-1:0] SEL_PORT_A = 4'h0;
   localparam logic [SEL_W-1:0] SEL_PORT_B = 4'h1;
   localparam logic [SEL_W-1:0] SEL_PORT_C = 4'h2;

   typedef enum logic [1:0] {
      SCS_PORT_A    = 2'b00,
      SCS_PORT_B    = 2'b01,
      SCS_PORT_C    = 2'b10,
      SCS_PORT_NONE = 2'b11
   } scs_port_e;

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        secure;
      logic        priv;
   } scs_req_s;

   typedef struct packed {
      logic attribution_unit_freeze;
      logic s_protection_unit_freeze;
      logic s_vector_and_ctrl_freeze;
      logic ns_protection_unit_freeze;
      logic ns_vector_base_freeze;
   } scs_lock_s;

   typedef struct packed {
      logic inexact_irq_on;
      logic denormal_irq_on;
      logic overflow_irq_on;
      logic underflow_irq_on;
      logic div_zero_irq_on;
      logic invalid_op_irq_on;
   } scs_float_s;

endpackage

// ==== core/scs_regs.sv ====
// System configuration register bank: line source selectors, I/O
// compensation cell control, security attribution, float interrupt
// enables, processor lock bits and safety routing.
// Assumes a single-cycle register port synchronous to clk.
`timescale 1ns/1ps

// Overview of operation
// - Line 8 selects port A, B or C
// - Lines 9-13 select only port A or B
// - Lines 14, 15 select port A, B or C
// - Compensation enable bit powers cell up
// - Bit 8 reports compensation cell ready
// - Attribution register secure only, else event
// - Extension off: attribution and locks read zero
// - Attribution bit 3 makes float enables secure-write
// - Attribution bit 2 makes second RAM secure-write
// - Attribution bit 1 guards safety register
// - Attribution bit 0 guards block clock control
// - Float enables reset to 0x1f
// - Float enable bits gate each exception
// - Float and lock registers privileged only
// - Non-secure MPU freeze, set once
// - Non-secure vector base freeze, set once
// - Non-secure lock has no security gating
// - Secure lock secure-write only, else event
// - Attribution unit freeze, set once
// - Secure MPU freeze, set once
// - Secure vector and control freeze, set once
// - Low-voltage break link lock, set once
// - Lock routes detector, freezes its fields
// - CPU hang break link, set once
module scs_regs (
   input  wire logic                 clk,
   input  wire logic                 reset,
   input  wire logic                 security_extension_on,
   input  wire scs_pkg::scs_req_s    req,
   output logic [31:0]               rdata,
   output logic                      illegal_access,
   input  wire logic                 comp_cell_ready,
   output logic                      comp_cell_on,
   output scs_pkg::scs_port_e [15:8] line_port,
   output logic [15:8]               line_pin_sel,
   output scs_pkg::scs_float_s       float_irq_en,
   output scs_pkg::scs_lock_s        cpu_locks,
   output logic                      float_regs_secure_only,
   output logic                      second_ram_secure_only,
   output logic                      safety_cfg_secure_only,
   output logic                      block_clock_secure_only,
   input  wire logic                 lowvolt_irq,
   input  wire logic                 cpu_hang,
   output logic                      timer_break,
   output logic                      lowvolt_fields_frozen
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   logic [scs_pkg::SEL_REG_W-1:0]  sel2_r, sel2_nxt;
   logic [scs_pkg::SEL_REG_W-1:0]  sel3_r, sel3_nxt;
   logic                           comp_r, comp_nxt;
   logic [scs_pkg::SEC_ATTR_W-1:0] attr_r, attr_nxt;
   logic [scs_pkg::FLOAT_W-1:0]    flt_r, flt_nxt;
   logic [scs_pkg::NS_LOCK_W-1:0]  nsl_r, nsl_nxt;
   logic [scs_pkg::S_LOCK_W-1:0]   sl_r, sl_nxt;
   logic                           lowv_r, lowv_nxt;
   logic                           hang_r, hang_nxt;
   logic [31:0]                    rdata_r, rdata_nxt;
   logic                           ill_r, ill_nxt;

   logic        acc;
   logic        ns_tz;
   logic [31:0] wd;
   logic        hit_sel2;
   logic        hit_sel3;
   logic        hit_comp;
   logic        hit_attr;
   logic        hit_flt;
   logic        hit_nsl;
   logic        hit_sl;
   logic        hit_safe;
   logic        rd_attr;
   logic        rd_flt;
   logic        rd_nsl;
   logic        rd_sl;
   logic        rd_safe;
   logic        wr_sel2;
   logic        wr_sel3;
   logic        wr_comp;
   logic        wr_attr;
   logic        wr_flt;
   logic        wr_nsl;
   logic        wr_sl;
   logic        wr_safe;
   logic        bad;

   assign acc   = req.wr | req.rd;
   assign ns_tz = security_extension_on & ~req.secure;
   assign wd    = req.wdata;

   // ------------------------------------------------------------------
   // Offset decode
   // ------------------------------------------------------------------
   // Unmapped offsets read zero and take no write
   always_comb begin
      hit_sel2 = 1'b0;
      hit_sel3 = 1'b0;
      hit_comp = 1'b0;
      hit_attr = 1'b0;
      hit_flt  = 1'b0;
      hit_nsl  = 1'b0;
      hit_sl   = 1'b0;
      hit_safe = 1'b0;
      if (req.addr == scs_pkg::OFS_EXT_SEL_2) begin
         hit_sel2 = 1'b1;
      end else if (req.addr == scs_pkg::OFS_EXT_SEL_3) begin
         hit_sel3 = 1'b1;
      end else if (req.addr == scs_pkg::OFS_COMP_CTRL) begin
         hit_comp = 1'b1;
      end else if (req.addr == scs_pkg::OFS_SEC_ATTR) begin
         hit_attr = 1'b1;
      end else if (req.addr == scs_pkg::OFS_FLOAT_IRQ) begin
         hit_flt = 1'b1;
      end else if (req.addr == scs_pkg::OFS_NS_LOCK) begin
         hit_nsl = 1'b1;
      end else if (req.addr == scs_pkg::OFS_S_LOCK) begin
         hit_sl = 1'b1;
      end else if (req.addr == scs_pkg::OFS_SAFETY_CFG) begin
         hit_safe = 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Access rights
   // ------------------------------------------------------------------
   // Illegal access events only arise with the extension on
   always_comb begin
      rd_attr = hit_attr & security_extension_on & req.secure;
      rd_flt  = hit_flt & req.priv;
      rd_nsl  = hit_nsl & security_extension_on & req.priv;
      rd_sl   = hit_sl & security_extension_on & req.secure & req.priv;
      rd_safe = hit_safe & ~(ns_tz & attr_r[scs_pkg::ATTR_SAFE_BIT]);
      wr_sel2 = req.wr & hit_sel2;
      wr_sel3 = req.wr & hit_sel3;
      wr_comp = req.wr & hit_comp;
      wr_attr = req.wr & rd_attr;
      wr_flt  = req.wr & rd_flt
                & ~(ns_tz & attr_r[scs_pkg::ATTR_FLOAT_BIT]);
      wr_nsl  = req.wr & rd_nsl;
      wr_sl   = req.wr & rd_sl;
      wr_safe = req.wr & rd_safe;
      bad     = acc & ns_tz & (hit_attr | hit_sl
                | (hit_safe & attr_r[scs_pkg::ATTR_SAFE_BIT]));
   end

   // ------------------------------------------------------------------
   // Line source selectors
   // ------------------------------------------------------------------
   // Reserved codes are kept and decode to no port
   always_comb begin
      sel2_nxt = sel2_r;
      sel3_nxt = sel3_r;
      if (wr_sel2) begin
         sel2_nxt = wd[scs_pkg::SEL_REG_W-1:0];
      end
      if (wr_sel3) begin
         sel3_nxt = wd[scs_pkg::SEL_REG_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         sel2_r <= '0;
         sel3_r <= '0;
      end else begin
         sel2_r <= sel2_nxt;
         sel3_r <= sel3_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Compensation cell control
   // ------------------------------------------------------------------
   // The ready flag is not stored; reads see the cell live
   always_comb begin
      comp_nxt = comp_r;
      if (wr_comp) begin
         comp_nxt = wd[scs_pkg::COMP_ON_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         comp_r <= 1'b0;
      end else begin
         comp_r <= comp_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Security attribution
   // ------------------------------------------------------------------
   // Raw bits; the access checks gate them with the extension, the outputs do not
   always_comb begin
      attr_nxt = attr_r;
      if (wr_attr) begin
         attr_nxt = wd[scs_pkg::SEC_ATTR_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         attr_r <= '0;
      end else begin
         attr_r <= attr_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Float exception enables
   // ------------------------------------------------------------------
   // Privileged only, and secure only when attribution asks
   always_comb begin
      flt_nxt = flt_r;
      if (wr_flt) begin
         flt_nxt = wd[scs_pkg::FLOAT_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         flt_r <= scs_pkg::FLOAT_RESET;
      end else begin
         flt_r <= flt_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Processor lock bits
   // ------------------------------------------------------------------
   always_comb begin
      nsl_nxt = nsl_r;
      sl_nxt  = sl_r;
      // Write one to set; only reset clears
      if (wr_nsl) begin
         nsl_nxt = nsl_r | wd[scs_pkg::NS_LOCK_W-1:0];
      end
      if (wr_sl) begin
         sl_nxt = sl_r | wd[scs_pkg::S_LOCK_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         nsl_r <= '0;
         sl_r  <= '0;
      end else begin
         nsl_r <= nsl_nxt;
         sl_r  <= sl_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Safety routing locks
   // ------------------------------------------------------------------
   // Write one to set; only reset clears
   always_comb begin
      lowv_nxt = lowv_r;
      hang_nxt = hang_r;
      if (wr_safe) begin
         lowv_nxt = lowv_r | wd[scs_pkg::SAFE_LOWV_BIT];
         hang_nxt = hang_r | wd[scs_pkg::SAFE_HANG_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         lowv_r <= 1'b0;
         hang_r <= 1'b0;
      end else begin
         lowv_r <= lowv_nxt;
         hang_r <= hang_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Read data and illegal access event
   // ------------------------------------------------------------------
   // A write with read returns the value held before the write
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (!req.rd) begin
         rdata_nxt = 32'h0000_0000;
      end else if (hit_sel2) begin
         rdata_nxt = 32'(sel2_r);
      end else if (hit_sel3) begin
         rdata_nxt = 32'(sel3_r);
      end else if (hit_comp) begin
         rdata_nxt[scs_pkg::COMP_ON_BIT]  = comp_r;
         rdata_nxt[scs_pkg::COMP_RDY_BIT] = comp_cell_ready;
      end else if (rd_attr) begin
         rdata_nxt = 32'(attr_r);
      end else if (rd_flt) begin
         rdata_nxt = 32'(flt_r);
      end else if (rd_nsl) begin
         rdata_nxt = 32'(nsl_r);
      end else if (rd_sl) begin
         rdata_nxt = 32'(sl_r);
      end else if (rd_safe) begin
         rdata_nxt[scs_pkg::SAFE_LOWV_BIT] = lowv_r;
         rdata_nxt[scs_pkg::SAFE_HANG_BIT] = hang_r;
      end
      ill_nxt = bad;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_r <= 32'h0000_0000;
         ill_r   <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         ill_r   <= ill_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Line source decode
   // ------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < scs_pkg::NUM_LINES; g = g + 1) begin : g_line
         localparam int LINE = g + 8;
         localparam bit HAS_C = (LINE == 8) || (LINE >= 14);
         logic [scs_pkg::SEL_W-1:0] code;
         if (g < 4) begin : g_lo
            assign code = sel2_r[g*scs_pkg::SEL_W +: scs_pkg::SEL_W];
         end else begin : g_hi
            assign code = sel3_r[(g-4)*scs_pkg::SEL_W +: scs_pkg::SEL_W];
         end
         always_comb begin
            if (code == scs_pkg::SEL_PORT_A) begin
               line_port[LINE] = scs_pkg::SCS_PORT_A;
            end else if (code == scs_pkg::SEL_PORT_B) begin
               line_port[LINE] = scs_pkg::SCS_PORT_B;
            end else if (HAS_C && code == scs_pkg::SEL_PORT_C) begin
               line_port[LINE] = scs_pkg::SCS_PORT_C;
            end else begin
               line_port[LINE] = scs_pkg::SCS_PORT_NONE;
            end
         end
         assign line_pin_sel[LINE] = (line_port[LINE] != scs_pkg::SCS_PORT_NONE);
      end
   endgenerate

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign rdata          = rdata_r;
   assign illegal_access = ill_r;
   assign comp_cell_on   = comp_r;
   assign float_irq_en   = flt_r;

   assign cpu_locks.attribution_unit_freeze   = sl_r[2];
   assign cpu_locks.s_protection_unit_freeze  = sl_r[1];
   assign cpu_locks.s_vector_and_ctrl_freeze  = sl_r[0];
   assign cpu_locks.ns_protection_unit_freeze = nsl_r[1];
   assign cpu_locks.ns_vector_base_freeze     = nsl_r[0];

   // Attribution outputs are raw; they stay set with the extension off
   assign float_regs_secure_only  = attr_r[scs_pkg::ATTR_FLOAT_BIT];
   assign second_ram_secure_only  = attr_r[scs_pkg::ATTR_RAM_BIT];
   assign safety_cfg_secure_only  = attr_r[scs_pkg::ATTR_SAFE_BIT];
   assign block_clock_secure_only = attr_r[scs_pkg::ATTR_CLK_BIT];

   assign lowvolt_fields_frozen = lowv_r;
   assign timer_break = (lowv_r & lowvolt_irq) | (hang_r & cpu_hang);

endmodule

// ==== tb/scs_regs_properties.sv ====
// Concurrent checks on the ports of the configuration register bank.
// Assumes scs_pkg is compiled first; bound to scs_regs below.
`timescale 1ns/1ps
module scs_regs_properties (
   input wire logic                      clk,
   input wire logic                      reset,
   input wire logic                      security_extension_on,
   input wire scs_pkg::scs_req_s         req,
   input wire logic [31:0]               rdata,
   input wire logic                      illegal_access,
   input wire logic                      comp_cell_ready,
   input wire scs_pkg::scs_port_e [15:8] line_port,
   input wire scs_pkg::scs_float_s       float_irq_en,
   input wire scs_pkg::scs_lock_s        cpu_locks,
   input wire logic                      lowvolt_irq,
   input wire logic                      timer_break,
   input wire logic                      lowvolt_fields_frozen
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // -------------------------------------------------------------
   // Access sequences
   // -------------------------------------------------------------
   sequence bad_attr_s;
      (req.rd || req.wr) && req.addr == scs_pkg::OFS_SEC_ATTR
         && security_extension_on && !req.secure;
   endsequence
   sequence off_rd_s;
      req.rd && !security_extension_on && (req.addr == 8'h40
         || req.addr == 8'h4c || req.addr == 8'h50);
   endsequence
   attr_event_a: assert property (bad_attr_s |=> illegal_access
      && rdata == 32'h0) else $error("attribution access not refused");
   ext_off_a: assert property (off_rd_s |=> rdata == 32'h0
      && !illegal_access) else $error("ext off read not zero");
   float_reset_a: assert property ($fell(reset) |->
      float_irq_en == scs_pkg::FLOAT_RESET && cpu_locks == '0)
      else $error("bad value after reset");
   pulse_cause_a: assert property (illegal_access |->
      $past(req.rd || req.wr)) else $error("event without access");
   unpriv_float_a: assert property (req.rd && !req.priv &&
      req.addr == scs_pkg::OFS_FLOAT_IRQ |=> rdata == 32'h0)
      else $error("unprivileged read not zero");
   lock_sticky_a: assert property ((cpu_locks & $past(cpu_locks))
      == $past(cpu_locks)) else $error("lock bit cleared");
   comp_ready_a: assert property (req.rd && req.addr == 8'h20 |=>
      rdata[8] == $past(comp_cell_ready)) else $error("ready flag wrong");
   line_no_c_a: assert property (line_port[9] != scs_pkg::SCS_PORT_C
      && line_port[13] != scs_pkg::SCS_PORT_C) else $error("port C on line");
   lowv_break_a: assert property (lowvolt_fields_frozen &&
      lowvolt_irq |-> timer_break) else $error("break not driven");
endmodule

bind scs_regs scs_regs_properties chk_u (.clk(clk), .reset(reset),
   .security_extension_on(security_extension_on), .req(req),
   .rdata(rdata), .illegal_access(illegal_access),
   .comp_cell_ready(comp_cell_ready), .line_port(line_port),
   .float_irq_en(float_irq_en), .cpu_locks(cpu_locks),
   .lowvolt_irq(lowvolt_irq), .timer_break(timer_break),
   .lowvolt_fields_frozen(lowvolt_fields_frozen));

// ==== tb/test_system_config_security_regs.sv ====
// Self-checking bench for scs_regs: random and corner register traffic.
// Assumes scs_pkg and the bound checker are compiled first.
`timescale 1ns/1ps
module test_system_config_security_regs;
   logic                      clk = 1'b0;
   logic                      reset = 1'b1;
   logic                      sec_ext = 1'b1;
   scs_pkg::scs_req_s         req = '0;
   logic [31:0]               rdata, rd_v;
   logic                      illegal_access, ev_v, comp_cell_on;
   logic                      ready = 1'b1;
   scs_pkg::scs_port_e [15:8] line_port;
   logic [15:8]               line_pin_sel;
   scs_pkg::scs_float_s       float_irq_en;
   scs_pkg::scs_lock_s        cpu_locks;
   logic [3:0]                attr;
   logic                      lowv, lv_irq = 1'b0, hang = 1'b0, brk;
   logic [15:0]               lfsr = 16'h8c09;
   logic [15:0]               sel;
   logic [1:0]                pv;
   int                        n_fail = 0, cmp_count = 0, b;
   logic [7:0]  ofs [9] = '{8'h10, 8'h14, 8'h20, 8'h40, 8'h48, 8'h4c,
                            8'h50, 8'h54, 8'h30};
   logic [31:0] rst_v [9] = '{32'h0, 32'h0, 32'h100, 32'h0, 32'h1f,
                              32'h0, 32'h0, 32'h0, 32'h0};

   scs_regs dut_u (.clk(clk), .reset(reset),
      .security_extension_on(sec_ext), .req(req), .rdata(rdata),
      .illegal_access(illegal_access), .comp_cell_ready(ready),
      .comp_cell_on(comp_cell_on), .line_port(line_port),
      .line_pin_sel(line_pin_sel), .float_irq_en(float_irq_en),
      .cpu_locks(cpu_locks), .float_regs_secure_only(attr[3]),
      .second_ram_secure_only(attr[2]), .safety_cfg_secure_only(attr[1]),
      .block_clock_secure_only(attr[0]), .lowvolt_irq(lv_irq),
      .cpu_hang(hang), .timer_break(brk), .lowvolt_fields_frozen(lowv));

   always #2.5 clk = ~clk;

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [1:0] exp_port(input int ln, input logic [3:0] c);
      if (c < 4'h2) return c[1:0];
      if (c == 4'h2 && (ln == 8 || ln > 13)) return 2'h2;
      return 2'h3;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Every access reads too; a write returns the old value
   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic s, input logic p);
      @(posedge clk);
      #1 req = '{w, 1'b1, a, d, s, p};
      @(posedge clk);
      #1 req = '0;
      rd_v = rdata;
      ev_v = illegal_access;
   endtask
   task automatic chk_re(input logic [31:0] r, input logic e);
      chk(rd_v, r);
      chk(32'(ev_v), 32'(e));
   endtask
   task automatic end_sim();
      if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      #100000;
      n_fail++;
      end_sim();
   end

   initial begin
      repeat (10) @(posedge clk);
      #1 reset = 1'b0;
      foreach (ofs[i]) begin
         acc(1'b0, ofs[i], 32'h0, 1'b1, 1'b1);
         chk_re(rst_v[i], 1'b0);
      end
      for (int i = 0; i < 10; i++) begin
         lfsr = nxt(lfsr);
         sel = (i < 2) ? 16'h2222 : lfsr;
         b = 8 + 4 * (i % 2);
         acc(1'b1, 8'(b + 8), {16'h0, sel}, 1'b1, 1'b1);
         acc(1'b0, 8'(b + 8), 32'h0, 1'b1, 1'b1);
         chk(rd_v, {16'h0, sel});
         for (int k = 0; k < 4; k++) begin
            pv = exp_port(b + k, sel[4*k +: 4]);
            chk(32'(line_port[b + k]), 32'(pv));
            chk(32'(line_pin_sel[b + k]), 32'(pv != 2'h3));
         end
      end
      acc(1'b1, 8'h20, 32'h1, 1'b0, 1'b0);
      chk(32'(comp_cell_on), 32'h1);
      ready = 1'b0;
      acc(1'b0, 8'h20, 32'h0, 1'b1, 1'b1);
      chk(rd_v, 32'h1);
      acc(1'b1, 8'h40, 32'hf, 1'b0, 1'b1);
      chk_re(32'h0, 1'b1);
      acc(1'b1, 8'h40, 32'hf, 1'b1, 1'b0);
      chk(32'(attr), 32'hf);
      acc(1'b1, 8'h48, 32'h2a, 1'b0, 1'b1);
      chk(32'(float_irq_en), 32'h1f);
      for (int k = 0; k < 6; k++) begin
         acc(1'b1, 8'h48, 32'h1 << k, 1'b1, 1'b1);
         chk(32'(float_irq_en), 32'h1 << k);
      end
      acc(1'b1, 8'h48, 32'h3f, 1'b1, 1'b0);
      chk_re(32'h0, 1'b0);
      chk(32'(float_irq_en), 32'h20);
      acc(1'b1, 8'h54, 32'h5, 1'b0, 1'b1);
      chk_re(32'h0, 1'b1);
      {lv_irq, hang} = 2'b11;
      #1 chk(32'(brk), 32'h0);
      acc(1'b1, 8'h54, 32'h5, 1'b1, 1'b0);
      chk(32'(lowv), 32'h1);
      hang = 1'b0;
      #1 chk(32'(brk), 32'h1);
      @(posedge clk);
      #1 {lv_irq, hang} = 2'b01;
      #1 chk(32'(brk), 32'h1);
      acc(1'b1, 8'h4c, 32'h3, 1'b0, 1'b1);
      chk_re(32'h0, 1'b0);
      acc(1'b1, 8'h4c, 32'h0, 1'b0, 1'b1);
      chk(32'(cpu_locks), 32'h3);
      acc(1'b1, 8'h50, 32'h7, 1'b0, 1'b1);
      chk_re(32'h0, 1'b1);
      acc(1'b1, 8'h50, 32'h7, 1'b1, 1'b0);
      chk(32'(cpu_locks), 32'h3);
      acc(1'b1, 8'h50, 32'h7, 1'b1, 1'b1);
      chk(32'(cpu_locks), 32'h1f);
      sec_ext = 1'b0;
      for (int k = 3; k < 7; k++) begin
         acc(1'b1, ofs[k + (k > 3)], 32'h0, 1'b1, 1'b1);
         chk_re((k == 6) ? 32'h5 : 32'h0, 1'b0);
      end
      chk(32'(attr), 32'hf);
      sec_ext = 1'b1;
      reset = 1'b1;
      repeat (3) @(posedge clk);
      #1 reset = 1'b0;
      chk(32'(cpu_locks), 32'h0);
      acc(1'b0, 8'h54, 32'h0, 1'b1, 1'b1);
      chk_re(32'h0, 1'b0);
      acc(1'b1, 8'h48, 32'h15, 1'b0, 1'b1);
      chk(32'(float_irq_en), 32'h15);
      end_sim();
   end
endmodule
